// File: hdl/adc_seq_regs.vh
// Register map, field positions, reset values and timing counts of the conversion sequencer.
`ifndef ADC_SEQ_REGS_VH
`define ADC_SEQ_REGS_VH
// ==================================================
// Register byte offsets.
`define OFF_SC_A 8'h00
`define OFF_SC_B 8'h04
`define OFF_CFG1 8'h08
`define OFF_CFG2 8'h0C
`define OFF_SC2 8'h10
`define OFF_CMPV 8'h14
`define OFF_RES_A_HI 8'h18
`define OFF_RES_A_LO 8'h1C
`define OFF_RES_B_HI 8'h20
`define OFF_RES_B_LO 8'h24
// ==================================================
// Status-control fields: channel [4:0], differential 5, irq enable 6, done 7 (read only).
`define SC_DIFF 5
`define SC_IEN 6
`define CH_OFF 5'h1F
`define SC_RST 7'h1F
// Configuration 1: clock select [1:0], divide [3:2], long sample 4, mode [6:5], low power 7.
`define CFG1_LSMP 4
`define CFG1_LPC 7
// Configuration 2: long sample select [1:0], high speed 2, async clock out enable 3.
`define CFG2_HSC 2
`define CFG2_ACKEN 3
// Status-control 2: trigger 0, compare 1, compare greater-equal 2, continuous 3, average 4, count [6:5].
`define SC2_TRG 0
`define SC2_CMPE 1
`define SC2_CMPGT 2
`define SC2_CONT 3
`define SC2_AVERAGE_ENABLE 4
// Mode codes.
`define MODE_8 2'b00
`define MODE_12 2'b01
`define MODE_10 2'b10
`define MODE_16 2'b11
`define ICLK_ASYNC 2'b11
// ==================================================
// Timing in converter clock cycles unless noted.
`define SFC_BUS 10'h005
`define SFC_LONG 6'h03
`define SFC_SHORT 6'h05
`define ASYNC_WAKE_NS 5000
`define CLK_MHZ 125
`define ASYNC_WAKE_CYC ((`ASYNC_WAKE_NS*`CLK_MHZ+999)/1000)
`define SMP_BASE 6'h04
`define BCT_8SE 6'h11
`define BCT_9DF 6'h1B
`define BCT_10SE 6'h14
`define BCT_11DF 6'h1E
`define BCT_16SE 6'h19
`define BCT_16DF 6'h22
`define LST_00 6'h14
`define LST_01 6'h0C
`define LST_10 6'h06
`define LST_11 6'h02
`define HSC_ADD 6'h04
`define AVG_4 6'h04
`define AVG_8 6'h08
`define AVG_16 6'h10
`define AVG_32 6'h20
`define AVG_1 6'h01
`endif

// File: hdl/adc_conversion_sequencer.v
// Conversion sequencer of a successive-approximation converter with an AHB-Lite register slave.
`timescale 1ns/1ps
// How it works
// - Software mode: writing control A with a real channel starts a conversion.
// - Hardware mode: trigger edge with a select line starts on that select's channel.
// - Continuous mode restarts a conversion after each completion until aborted.
// - Averaging chains conversions to the count; continuous starts a fresh set.
// - Averaging count is 1 when disabled, else 4, 8, 16 or 32.
// - With averaging, the done flag sets only after the last conversion.
// - With compare on, result stored and flag set only when compare holds.
// - Interrupt raised when a done flag sets with its irq enable high.
// - Except 8-bit single-ended, a half-read result blocks and discards the new one.
// - A blocked transfer restarts conversion, except single with failed compare terminates.
// - Writing control A during its conversion aborts; software mode restarts it.
// - Writing control B during its conversion aborts without restarting.
// - Writing configuration 1, configuration 2, status-control 2 or compare value aborts a conversion in progress.
// - Reset, deep stop, or light stop without async clock abort conversions.
// - Abort keeps results, except reset and deep stop clear them.
// - Idle until started; async generator runs only when needed or enabled.
// - Sample first, then isolate and approximate, then transfer the result.
// - Total time is first adder plus count times per-conversion time.
// - First adder is 3 or 5 converter cycles, 5 bus cycles, plus async wake.
// - Base conversion time follows the mode and differential table.
// - Long sample adds 20, 12, 6 or 2 cycles, else nothing.
// - High speed adds 4 converter cycles to every conversion.
// - A trigger edge during a conversion is ignored.
// - Converter clock is the source divided by 1, 2, 4 or 8.
`include "adc_seq_regs.vh"
module adc_conversion_sequencer (
  input wire clk_sys_i, // System clock, 125 MHz.
  input wire rst_i, // Asynchronous reset, active high.
  input wire hsel_i, // AHB slave select.
  input wire [31:0] haddr_i, // AHB address.
  input wire [1:0] htrans_i, // AHB transfer type.
  input wire hwrite_i, // AHB write.
  input wire [2:0] hsize_i, // AHB size, word only.
  input wire [31:0] hwdata_i, // AHB write data.
  input wire hready_i, // AHB bus ready.
  output reg [31:0] hrdata_o, // AHB read data.
  output reg hreadyout_o, // AHB slave ready.
  output reg hresp_o, // AHB response, always OKAY.
  input wire hw_trigger_i, // Hardware conversion trigger.
  input wire trig_sel_a_i, // Trigger select line for channel A.
  input wire trig_sel_b_i, // Trigger select line for channel B.
  input wire alt_clk_i, // Alternate clock, sampled.
  input wire deep_stop_i, // Deep stop mode.
  input wire light_stop_i, // Light stop mode.
  input wire [15:0] analog_data_i, // Value from the approximation core.
  output reg irq_o, // Done interrupt.
  output reg busy_o, // Conversion active.
  output reg sample_o, // Sample switch closed.
  output reg async_clk_run_o, // Async clock generator running.
  output reg [4:0] channel_o, // Channel in use.
  output reg diff_o // Differential input in use.
);
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_FIRST = 2'b01;
  localparam [1:0] ST_SAMPLE = 2'b10;
  localparam [1:0] ST_CONV = 2'b11;
  localparam integer WAKE_I = `ASYNC_WAKE_CYC;
  localparam [9:0] WAKE_CYC = WAKE_I[9:0];

  // ==================================================
  // Bus slave.
  reg [6:0] sc_r [0:1];
  reg done_r [0:1];
  reg hipend_r [0:1];
  reg [15:0] res_r [0:1];
  reg [7:0] cfg1_r;
  reg [3:0] cfg2_r;
  reg [6:0] sc2_r;
  reg [15:0] cmpv_r;
  reg wr_pend_r;
  reg [7:0] wr_addr_r;
  reg [1:0] state_r;
  reg act_ch_r;
  reg [5:0] cnt_r;
  reg [20:0] acc_r;
  wire ap = hsel_i & hready_i & htrans_i[1];
  wire rd_ap = ap & ~hwrite_i;
  wire [7:0] ra = haddr_i[7:0];
  wire wr_a = wr_pend_r & (wr_addr_r == `OFF_SC_A);
  wire wr_b = wr_pend_r & (wr_addr_r == `OFF_SC_B);
  wire wr_other = wr_pend_r & ((wr_addr_r == `OFF_CFG1) | (wr_addr_r == `OFF_CFG2) |
                  (wr_addr_r == `OFF_SC2) | (wr_addr_r == `OFF_CMPV));
  wire [1:0] wr_sc = {wr_b, wr_a};
  wire [1:0] rd_hi = {rd_ap & (ra == `OFF_RES_B_HI), rd_ap & (ra == `OFF_RES_A_HI)};
  wire [1:0] rd_lo = {rd_ap & (ra == `OFF_RES_B_LO), rd_ap & (ra == `OFF_RES_A_LO)};
  reg [31:0] rdata_nxt;

  // Read mux, evaluated in the address phase.
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (ra)
      `OFF_SC_A: rdata_nxt = {24'h00_0000, done_r[0], sc_r[0]};
      `OFF_SC_B: rdata_nxt = {24'h00_0000, done_r[1], sc_r[1]};
      `OFF_CFG1: rdata_nxt = {24'h00_0000, cfg1_r};
      `OFF_CFG2: rdata_nxt = {28'h000_0000, cfg2_r};
      `OFF_SC2: rdata_nxt = {22'h00_0000, (cnt_r != 6'h00), (state_r != ST_IDLE), 1'b0, sc2_r};
      `OFF_CMPV: rdata_nxt = {16'h0000, cmpv_r};
      `OFF_RES_A_HI: rdata_nxt = {24'h00_0000, res_r[0][15:8]};
      `OFF_RES_A_LO: rdata_nxt = {24'h00_0000, res_r[0][7:0]};
      `OFF_RES_B_HI: rdata_nxt = {24'h00_0000, res_r[1][15:8]};
      `OFF_RES_B_LO: rdata_nxt = {24'h00_0000, res_r[1][7:0]};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Address phase capture and zero-wait answers.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      wr_pend_r <= ap & hwrite_i;
      wr_addr_r <= ra;
      hrdata_o <= rd_ap ? rdata_nxt : 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // Global configuration registers; any write here marks a mode change.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cfg1_r <= 8'h00;
      cfg2_r <= 4'h0;
      sc2_r <= 7'h00;
      cmpv_r <= 16'h0000;
    end else if (wr_pend_r) begin
      if (wr_addr_r == `OFF_CFG1) cfg1_r <= hwdata_i[7:0];
      if (wr_addr_r == `OFF_CFG2) cfg2_r <= hwdata_i[3:0];
      if (wr_addr_r == `OFF_SC2) sc2_r <= hwdata_i[6:0];
      if (wr_addr_r == `OFF_CMPV) cmpv_r <= hwdata_i[15:0];
    end
  end

  // ==================================================
  // Conversion parameters.
  wire [1:0] iclk = cfg1_r[1:0];
  wire [1:0] div_sel = cfg1_r[3:2];
  wire lsmp = cfg1_r[`CFG1_LSMP];
  wire [1:0] mode = cfg1_r[6:5];
  wire acken = cfg2_r[`CFG2_ACKEN];
  wire trg = sc2_r[`SC2_TRG];
  wire cmpe = sc2_r[`SC2_CMPE];
  wire cont = sc2_r[`SC2_CONT];
  wire average_enable = sc2_r[`SC2_AVERAGE_ENABLE];
  wire diff = sc_r[act_ch_r][`SC_DIFF];
  reg [5:0] bct;
  reg [5:0] lst;
  reg [5:0] avg_num;
  reg [2:0] avg_sh;

  // Base time, long sample adder and averaging count tables.
  always @* begin
    case ({diff, mode})
      {1'b0, `MODE_8}: bct = `BCT_8SE;
      {1'b0, `MODE_12}: bct = `BCT_10SE;
      {1'b0, `MODE_10}: bct = `BCT_10SE;
      {1'b0, `MODE_16}: bct = `BCT_16SE;
      {1'b1, `MODE_8}: bct = `BCT_9DF;
      {1'b1, `MODE_16}: bct = `BCT_16DF;
      default: bct = `BCT_11DF;
    endcase
    case (cfg2_r[1:0])
      2'b00: lst = `LST_00;
      2'b01: lst = `LST_01;
      2'b10: lst = `LST_10;
      default: lst = `LST_11;
    endcase
    if (!lsmp) lst = 6'h00;
    case (sc2_r[6:5])
      2'b00: avg_num = `AVG_4;
      2'b01: avg_num = `AVG_8;
      2'b10: avg_num = `AVG_16;
      default: avg_num = `AVG_32;
    endcase
    case (sc2_r[6:5])
      2'b00: avg_sh = 3'h2;
      2'b01: avg_sh = 3'h3;
      2'b10: avg_sh = 3'h4;
      default: avg_sh = 3'h5;
    endcase
    if (!average_enable) begin
      avg_num = `AVG_1;
      avg_sh = 3'h0;
    end
  end
  // Sampling holds long sample on top of the base share; the rest is approximation.
  wire [5:0] smp_len = `SMP_BASE + lst;
  wire [5:0] conv_len = bct - `SMP_BASE + (cfg2_r[`CFG2_HSC] ? `HSC_ADD : 6'h00);

  // ==================================================
  // Clock sources and converter clock divider.
  reg active_r;
  reg half_r;
  reg alt_q_r;
  reg [1:0] async_cnt_r;
  reg [2:0] div_cnt_r;
  wire async_run = acken | ((iclk == `ICLK_ASYNC) & active_r);
  wire alt_tick = alt_clk_i & ~alt_q_r;
  wire async_tick = async_run & (async_cnt_r == 2'b11);
  reg src_tick;
  always @* begin
    case (iclk)
      2'b00: src_tick = 1'b1;
      2'b01: src_tick = half_r;
      2'b10: src_tick = alt_tick;
      default: src_tick = async_tick;
    endcase
  end
  wire [2:0] div_mask = (div_sel == 2'b00) ? 3'h0 : (div_sel == 2'b01) ? 3'h1 : (div_sel == 2'b10) ? 3'h3 : 3'h7;
  wire converter_clock_tick = active_r & src_tick & ((div_cnt_r & div_mask) == div_mask);

  // The divider is held still while idle so that the converter draws no clock.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      half_r <= 1'b0;
      alt_q_r <= 1'b0;
      async_cnt_r <= 2'b00;
      div_cnt_r <= 3'h0;
    end else begin
      half_r <= active_r & ~half_r;
      alt_q_r <= alt_clk_i;
      async_cnt_r <= async_run ? async_cnt_r + 2'b01 : 2'b00;
      if (!active_r) div_cnt_r <= 3'h0;
      else if (src_tick) div_cnt_r <= div_cnt_r + 3'h1;
    end
  end

  // ==================================================
  // Start and abort conditions.
  reg trig_q_r;
  reg [9:0] bus_cnt_r;
  reg [5:0] converter_clock_cnt_r;
  reg [15:0] samp_r;
  wire stop_blk = deep_stop_i | (light_stop_i & ~acken);
  wire trig_rise = hw_trigger_i & ~trig_q_r;
  wire hw_ch = ~trig_sel_a_i;
  wire hw_sel = trig_sel_a_i | trig_sel_b_i;
  wire sw_start = ~trg & wr_a & (hwdata_i[4:0] != `CH_OFF) & ~stop_blk;
  wire hw_start = trg & trig_rise & ~active_r & hw_sel & (sc_r[hw_ch][4:0] != `CH_OFF) & ~stop_blk;
  wire abort = active_r & (wr_sc[act_ch_r] | wr_other | stop_blk);

  // Completion of each conversion, and transfer after the last conversion of a set.
  wire conv_end = (state_r == ST_CONV) & converter_clock_tick & (converter_clock_cnt_r == 6'h01);
  wire [20:0] acc_sum = acc_r + {5'h00, samp_r};
  wire [20:0] avg_full = acc_sum >> avg_sh;
  wire [15:0] avg_res = avg_full[15:0];
  wire last = (cnt_r + 6'h01) == avg_num;
  wire cmp_ok = ~cmpe | (sc2_r[`SC2_CMPGT] ? (avg_res >= cmpv_r) : (avg_res < cmpv_r));
  wire blocked = ~((mode == `MODE_8) & ~diff) & hipend_r[act_ch_r];
  wire xfer = conv_end & last & cmp_ok & ~blocked & ~abort;
  wire restart = cont | (blocked & cmp_ok);
  wire [5:0] sfc_converter_clock = lsmp ? `SFC_LONG : `SFC_SHORT;
  wire wake = (iclk == `ICLK_ASYNC) & ~acken;
  reg [1:0] state_nxt;
  reg act_ch_nxt;
  reg [5:0] cnt_nxt;
  reg [20:0] acc_nxt;
  reg [9:0] bus_cnt_nxt;
  reg [5:0] converter_clock_cnt_nxt;

  // Sequencer: first adder, sampling, approximation, completion.
  always @* begin
    state_nxt = state_r;
    act_ch_nxt = act_ch_r;
    cnt_nxt = cnt_r;
    acc_nxt = acc_r;
    bus_cnt_nxt = bus_cnt_r;
    converter_clock_cnt_nxt = converter_clock_cnt_r;
    case (state_r)
      ST_FIRST: begin
        if (bus_cnt_r != 10'h000) bus_cnt_nxt = bus_cnt_r - 10'h001;
        else if (converter_clock_tick) begin
          converter_clock_cnt_nxt = converter_clock_cnt_r - 6'h01;
          if (converter_clock_cnt_r == 6'h01) begin
            state_nxt = ST_SAMPLE;
            converter_clock_cnt_nxt = smp_len;
          end
        end
      end
      ST_SAMPLE: begin
        if (converter_clock_tick) begin
          converter_clock_cnt_nxt = converter_clock_cnt_r - 6'h01;
          if (converter_clock_cnt_r == 6'h01) begin
            state_nxt = ST_CONV;
            converter_clock_cnt_nxt = conv_len;
          end
        end
      end
      ST_CONV: begin
        if (converter_clock_tick) converter_clock_cnt_nxt = converter_clock_cnt_r - 6'h01;
        if (conv_end) begin
          converter_clock_cnt_nxt = smp_len;
          state_nxt = ST_SAMPLE;
          if (!last) begin
            cnt_nxt = cnt_r + 6'h01;
            acc_nxt = acc_sum;
          end else begin
            cnt_nxt = 6'h00;
            acc_nxt = 21'h00_0000;
            if (!restart) state_nxt = ST_IDLE;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (abort) begin
      state_nxt = ST_IDLE;
      cnt_nxt = 6'h00;
      acc_nxt = 21'h00_0000;
    end
    if (sw_start | hw_start) begin
      state_nxt = ST_FIRST;
      act_ch_nxt = sw_start ? 1'b0 : hw_ch;
      cnt_nxt = 6'h00;
      acc_nxt = 21'h00_0000;
      bus_cnt_nxt = `SFC_BUS + (wake ? WAKE_CYC : 10'h000);
      converter_clock_cnt_nxt = sfc_converter_clock;
    end
  end

  // Sequencer registers and staged completion toward the result registers.
  reg cmpl_r;
  reg cmpl_ch_r;
  reg [15:0] cmpl_res_r;
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      active_r <= 1'b0;
      act_ch_r <= 1'b0;
      cnt_r <= 6'h00;
      acc_r <= 21'h00_0000;
      bus_cnt_r <= 10'h000;
      converter_clock_cnt_r <= 6'h00;
      samp_r <= 16'h0000;
      trig_q_r <= 1'b0;
      cmpl_r <= 1'b0;
      cmpl_ch_r <= 1'b0;
      cmpl_res_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      active_r <= state_nxt != ST_IDLE;
      act_ch_r <= act_ch_nxt;
      cnt_r <= cnt_nxt;
      acc_r <= acc_nxt;
      bus_cnt_r <= bus_cnt_nxt;
      converter_clock_cnt_r <= converter_clock_cnt_nxt;
      trig_q_r <= hw_trigger_i;
      if ((state_r == ST_SAMPLE) && (state_nxt == ST_CONV)) samp_r <= analog_data_i;
      cmpl_r <= xfer;
      cmpl_ch_r <= act_ch_r;
      cmpl_res_r <= avg_res;
    end
  end

  // ==================================================
  // Per-channel control, result, done flag and half-read tracking.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ch
      wire set_done = cmpl_r & (cmpl_ch_r == g) & ~deep_stop_i;
      always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          sc_r[g] <= `SC_RST;
          done_r[g] <= 1'b0;
          hipend_r[g] <= 1'b0;
          res_r[g] <= 16'h0000;
        end else begin
          if (wr_sc[g]) sc_r[g] <= hwdata_i[6:0];
          done_r[g] <= set_done | (done_r[g] & ~rd_lo[g] & ~wr_sc[g]);
          hipend_r[g] <= rd_hi[g] | (hipend_r[g] & ~rd_lo[g]);
          if (deep_stop_i) res_r[g] <= 16'h0000;
          else if (set_done) res_r[g] <= cmpl_res_r;
        end
      end
    end
  endgenerate

  // ==================================================
  // Registered outputs.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      busy_o <= 1'b0;
      sample_o <= 1'b0;
      async_clk_run_o <= 1'b0;
      channel_o <= `CH_OFF;
      diff_o <= 1'b0;
    end else begin
      irq_o <= (done_r[0] & sc_r[0][`SC_IEN]) | (done_r[1] & sc_r[1][`SC_IEN]);
      busy_o <= state_nxt != ST_IDLE;
      sample_o <= state_nxt == ST_SAMPLE;
      async_clk_run_o <= async_run;
      channel_o <= sc_r[act_ch_nxt][4:0];
      diff_o <= sc_r[act_ch_nxt][`SC_DIFF];
    end
  end
endmodule // adc_conversion_sequencer

// File: sim/adc_seq_chk.sv
// Concurrent checks on the conversion sequencer ports, bound to the design.
`timescale 1ns/1ps
`include "adc_seq_regs.vh"
module adc_seq_chk (
  input wire clk_sys_i, // Clock.
  input wire rst_i, // Reset.
  input wire hsel_i, // Select.
  input wire [31:0] haddr_i, // Address.
  input wire [1:0] htrans_i, // Transfer type.
  input wire hwrite_i, // Write.
  input wire [31:0] hwdata_i, // Write data.
  input wire hready_i, // Bus ready.
  input wire [31:0] hrdata_o, // Read data.
  input wire hw_trigger_i, // Trigger.
  input wire deep_stop_i, // Deep stop.
  input wire light_stop_i, // Light stop.
  input wire irq_o, // Interrupt.
  input wire busy_o, // Busy.
  input wire sample_o, // Sampling.
  input wire [4:0] channel_o // Channel.
);
  reg wr_q, rd_q, trg_r, acken_r, trig_d;
  reg [7:0] a_q;
  reg [4:0] ch_r;
  reg [3:0] st_h;
  wire st = wr_q | (hw_trigger_i & ~trig_d);
  // ==================================================
  // Helper state: data phases, mode bits and recent start events.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= 1'h0;
      rd_q <= 1'h0;
      a_q <= 8'h00;
      trg_r <= 1'h0;
      acken_r <= 1'h0;
      ch_r <= 5'h1F;
      trig_d <= 1'h0;
      st_h <= 4'h0;
    end else begin
      if (hready_i) begin
        wr_q <= hsel_i & htrans_i[1] & hwrite_i;
        rd_q <= hsel_i & htrans_i[1] & ~hwrite_i;
        a_q <= haddr_i[7:0];
      end
      if (wr_q && a_q == `OFF_SC2) trg_r <= hwdata_i[`SC2_TRG];
      if (wr_q && a_q == `OFF_CFG2) acken_r <= hwdata_i[`CFG2_ACKEN];
      if (wr_q && a_q == `OFF_SC_A) ch_r <= hwdata_i[4:0];
      trig_d <= hw_trigger_i;
      st_h <= {st_h[2:0], st};
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // ==================================================
  // Properties.
  property p_sw_start;
    wr_q && a_q == `OFF_SC_A && !trg_r && hwdata_i[4:0] != `CH_OFF && !deep_stop_i && !light_stop_i
      |-> ##[1:3] (busy_o && channel_o == ch_r);
  endproperty
  property p_idle_hold;
    !busy_o && !st && st_h == 4'h0 |=> !busy_o;
  endproperty
  property p_deep_abort;
    deep_stop_i |-> ##[1:3] !busy_o;
  endproperty
  property p_light_abort;
    light_stop_i && !acken_r |-> ##[1:3] !busy_o;
  endproperty
  property p_deep_clear;
    rd_q && deep_stop_i && $past(deep_stop_i, 3) && a_q >= `OFF_RES_A_HI && a_q <= `OFF_RES_B_LO
      |-> hrdata_o == 32'h0000_0000;
  endproperty
  property p_write_abort;
    wr_q && a_q >= `OFF_CFG1 && a_q <= `OFF_CMPV |-> ##[1:3] !busy_o;
  endproperty
  property p_trig_ignore;
    busy_o && $rose(hw_trigger_i) && !wr_q |=> $stable(channel_o);
  endproperty
  property p_irq_src;
    $rose(irq_o) |-> $past(busy_o, 4);
  endproperty
  property p_sample_busy;
    sample_o |-> busy_o;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("Software start missing.");
  a_idle_hold: assert property (p_idle_hold) else $error("Busy without a start.");
  a_deep_abort: assert property (p_deep_abort) else $error("Deep stop did not abort.");
  a_light_abort: assert property (p_light_abort) else $error("Light stop did not abort.");
  a_deep_clear: assert property (p_deep_clear) else $error("Result kept in deep stop.");
  a_write_abort: assert property (p_write_abort) else $error("Config write did not abort.");
  a_trig_ignore: assert property (p_trig_ignore) else $error("Busy trigger changed channel.");
  a_irq_src: assert property (p_irq_src) else $error("Interrupt without conversion.");
  a_sample_busy: assert property (p_sample_busy) else $error("Sampling while idle.");
  c_irq: cover property ($rose(irq_o));
  c_sample: cover property ($fell(sample_o));
  c_deep: cover property (deep_stop_i && $fell(busy_o));
endmodule // adc_seq_chk
bind adc_conversion_sequencer adc_seq_chk u_chk (.clk_sys_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
  .hwdata_i, .hready_i, .hrdata_o, .hw_trigger_i, .deep_stop_i, .light_stop_i, .irq_o, .busy_o, .sample_o,
  .channel_o);

// File: sim/trig_src_model.sv
// Behavioural hardware trigger source: one select line, then a trigger pulse.
`timescale 1ns/1ps
module trig_src_model (
  input wire clk_i, // Clock.
  input wire rst_i, // Reset, active high.
  input wire fire_i, // Request one trigger.
  input wire use_b_i, // Use select B.
  input wire busy_i, // Sequencer busy.
  output reg hw_trigger_o, // Trigger.
  output reg sel_a_o, // Select A.
  output reg sel_b_o // Select B.
);
  reg [3:0] cnt_r;
  // ==================================================
  // Select first, trigger three cycles later, select held until the conversion ends.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 4'h0;
      hw_trigger_o <= 1'h0;
      sel_a_o <= 1'h0;
      sel_b_o <= 1'h0;
    end else begin
      hw_trigger_o <= (cnt_r == 4'hD) || (cnt_r == 4'hC);
      if (fire_i) begin
        cnt_r <= 4'hF;
        sel_a_o <= ~use_b_i;
        sel_b_o <= use_b_i;
      end else begin
        if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
        if (cnt_r == 4'h0 && !busy_i) begin
          sel_a_o <= 1'h0;
          sel_b_o <= 1'h0;
        end
      end
    end
  end
endmodule // trig_src_model

// File: sim/adc_conversion_sequencer_test.sv
// Self-checking bench of the conversion sequencer.
`timescale 1ns/1ps
`include "adc_seq_regs.vh"
module adc_conversion_sequencer_test;
  reg clk_sys_i, rst_i, hsel, hwrite, fire, use_b, deep, light, rdy_s;
  reg [31:0] haddr, hwdata, rdat, rd_s;
  reg [1:0] htrans;
  reg [15:0] ana;
  wire [31:0] hrdata_o;
  wire hreadyout_o, hw_trig, sel_a, sel_b, irq_o, busy_o;
  int fail_count, checks_done, t0, n, k;
  int bct[8] = '{17, 27, 20, 30, 20, 30, 25, 34};
  int lst[4] = '{20, 12, 6, 2};
  adc_conversion_sequencer dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(), .hw_trigger_i(hw_trig), .trig_sel_a_i(sel_a),
    .trig_sel_b_i(sel_b), .alt_clk_i(1'h0), .deep_stop_i(deep), .light_stop_i(light), .analog_data_i(ana),
    .irq_o(irq_o), .busy_o(busy_o), .sample_o(), .async_clk_run_o(), .channel_o(), .diff_o());
  trig_src_model partner (.clk_i(clk_sys_i), .rst_i(rst_i), .fire_i(fire), .use_b_i(use_b), .busy_i(busy_o),
    .hw_trigger_o(hw_trig), .sel_a_o(sel_a), .sel_b_o(sel_b));
  // ==================================================
  // Clock and edge sampling of the bus answer.
  initial begin
    clk_sys_i = 1'h0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    rd_s <= hrdata_o;
    rdy_s <= hreadyout_o;
  end
  // ==================================================
  // Tasks.
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task step;
    @(posedge clk_sys_i);
    #1;
  endtask
  task rdy_wait;
    k = 0;
    do begin step; k++; end while (rdy_s !== 1'h1 && k < 50);
    if (k >= 50) begin fail_count++; finish_test; end
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy_wait;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy_wait;
    rdat = rd_s;
  endtask
  task wr(input [7:0] a, input [31:0] d); xfer(1'h1, a, d); endtask
  task rd(input [7:0] a); xfer(1'h0, a, 32'h0); endtask
  // Waits for the interrupt, counting cycles into n.
  task meas;
    n = 0;
    while (irq_o !== 1'h1 && n < 3000) begin step; n++; end
    if (n >= 3000) begin fail_count++; finish_test; end
  endtask
  task conv(input [31:0] c1, input [31:0] c2, input [31:0] s2, input [31:0] a);
    wr(`OFF_CFG1, c1); wr(`OFF_CFG2, c2); wr(`OFF_SC2, s2); wr(`OFF_SC_A, a);
    meas;
    rd(`OFF_RES_A_HI); rd(`OFF_RES_A_LO);
  endtask
  // ==================================================
  // Main sequence.
  initial begin
    {rst_i, hsel, hwrite, fire, use_b, deep, light} = 7'h40;
    {haddr, hwdata, htrans} = 0;
    ana = 16'hA5C3;
    fail_count = 0;
    checks_done = 0;
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    step;
    rd(`OFF_SC_A); chk(rdat, 32'h0000_001F);
    rd(`OFF_SC2); chk(rdat, 32'h0000_0000);
    conv(32'h0000_0060, 0, 0, 32'h0000_0040); t0 = n; chk(rdat, 32'h0000_00C3);
    $display("test reset and base done");
    for (int m = 0; m < 8; m++) begin
      conv((m >> 1) << 5, 0, 0, 32'h0000_0040 | ((m & 1) << 5)); chk(n - t0, bct[m] - 25);
    end
    for (int s = 0; s < 4; s++) begin
      conv(32'h0000_0070, s, 0, 32'h0000_0040); chk(n - t0, lst[s] - 2);
    end
    conv(32'h0000_0060, 32'h0000_0004, 0, 32'h0000_0040); chk(n - t0, 4);
    conv(32'h0000_0064, 0, 0, 32'h0000_0040); chk(n - t0, 29);
    for (int v = 0; v < 4; v++) begin
      conv(32'h0000_0060, 0, 32'h0000_0010 | (v << 5), 32'h0000_0040);
      chk(n - t0, ((4 << v) - 1) * 25);
      chk(rdat, 32'h0000_00C3);
    end
    $display("test timing done");
    ana <= 16'h1234;
    wr(`OFF_CMPV, 32'h0000_2000); wr(`OFF_SC2, 32'h0000_0006); wr(`OFF_SC_A, 32'h0000_0040);
    repeat (t0 + 20) step;
    chk({irq_o, busy_o}, 0);
    rd(`OFF_RES_A_LO); chk(rdat, 32'h0000_00C3);
    wr(`OFF_CMPV, 32'h0000_1000);
    conv(32'h0000_0060, 0, 32'h0000_0006, 32'h0000_0040); chk(rdat, 32'h0000_0034);
    $display("test compare done");
    ana <= 16'h5A5A;
    wr(`OFF_SC2, 0); wr(`OFF_SC_A, 32'h0000_0040); rd(`OFF_RES_A_HI);
    repeat (t0 + 8) step;
    chk({irq_o, busy_o}, 1);
    rd(`OFF_RES_A_LO); meas; rd(`OFF_RES_A_HI); rd(`OFF_RES_A_LO); chk(rdat, 32'h0000_005A);
    wr(`OFF_SC_A, 32'h0000_0040); repeat (10) step; wr(`OFF_SC_A, 32'h0000_0040);
    meas; chk(n, t0);
    rd(`OFF_RES_A_LO);
    ana <= 16'h0F0F;
    wr(`OFF_SC_A, 32'h0000_0040); repeat (10) step; wr(`OFF_CMPV, 0); repeat (4) step;
    chk(busy_o, 0);
    rd(`OFF_RES_A_LO); chk(rdat, 32'h0000_005A);
    $display("test block and abort done");
    wr(`OFF_SC2, 32'h0000_0008); wr(`OFF_SC_A, 32'h0000_0040);
    meas; rd(`OFF_RES_A_HI); rd(`OFF_RES_A_LO); chk(rdat, 32'h0000_000F);
    step; meas; chk(busy_o, 1);
    rd(`OFF_RES_A_LO); wr(`OFF_SC2, 0); repeat (4) step;
    chk(busy_o, 0);
    $display("test continuous done");
    ana <= 16'h3C3C;
    wr(`OFF_SC_B, 32'h0000_0043); wr(`OFF_SC2, 32'h0000_0001);
    use_b <= 1'h1; fire <= 1'h1; step; fire <= 1'h0;
    repeat (20) step;
    fire <= 1'h1; step; fire <= 1'h0;
    meas; rd(`OFF_SC_B); chk(rdat, 32'h0000_00C3);
    rd(`OFF_RES_B_HI); rd(`OFF_RES_B_LO); chk(rdat, 32'h0000_003C);
    repeat (t0) step;
    chk(busy_o, 0);
    $display("test hardware trigger done");
    wr(`OFF_SC2, 0); wr(`OFF_SC_A, 32'h0000_0040); repeat (10) step; deep <= 1'h1; repeat (4) step;
    chk(busy_o, 0);
    rd(`OFF_RES_A_HI); chk(rdat, 0);
    deep <= 1'h0;
    wr(`OFF_SC_A, 32'h0000_0040); repeat (10) step; light <= 1'h1; repeat (4) step;
    chk(busy_o, 0);
    light <= 1'h0;
    $display("test stop modes done");
    finish_test;
  end
endmodule // adc_conversion_sequencer_test
